//--- src/sarseq_defines.vh
/*
 sarseq_defines.vh: constants for the successive-approximation sequencer.
 assumes: included by the sequencer only; definitions, no logic.
*/
`ifndef SARSEQ_DEFINES_VH
`define SARSEQ_DEFINES_VH

// machine cycle slots (12 clocks a machine cycle, 6 states x 2 phases)
`define SARSEQ_CLK_PER_MC   4'd12
`define SARSEQ_SLOT_STATE1_PHASE2    4'h1
`define SARSEQ_SLOT_STATE6_PHASE2    4'hb
`define SARSEQ_SLOT_LAST    4'hb

// conversion timing in machine cycles from internal start
`define SARSEQ_CONV_MC      6'd50
`define SARSEQ_SAMPLE_MC    6'd8
`define SARSEQ_SMP_FIRST    6'd2
`define SARSEQ_SMP_LAST     6'd5
`define SARSEQ_AZ1_END      6'd4
`define SARSEQ_AZ2_END      6'd6
`define SARSEQ_AZ3_END      6'd8
`define SARSEQ_BIT_FIRST    6'd8
`define SARSEQ_BITS         4'd10
`define SARSEQ_STEP_PHASE   2'b11
`define SARSEQ_FLAG_DELAY   2'd2

// result and approximation register, channel field width
`define SARSEQ_MIDSCALE     10'h200
`define SARSEQ_ZERO10       10'h000
`define SARSEQ_CHAN_W       3

`endif

//--- src/sarseq_core.v
/*
 sarseq_core.v: digital sequencer of an 8-input 10-bit successive-approximation
 converter: start detection, sample and auto-zero timing, binary search.
 assumes: clk is the oscillator; a machine cycle is 12 clocks; the comparator
 decision arrives as a level that may change asynchronously.
*/
`timescale 1ns/1ps
`include "sarseq_defines.vh"

module sarseq_core #(
    parameter CHAN_W = `SARSEQ_CHAN_W
) (
    // clock and reset
    input  wire              clk,
    input  wire              nrst,
    // cpu side
    input  wire              sw_start_wr,
    input  wire [CHAN_W-1:0] chan_sel_wr,
    input  wire              chan_sel_we,
    output reg               conversion_start_flag_q,
    output reg  [9:0]        result_q,
    output reg               conv_done_q,
    output reg               start_pulse_q,
    output reg  [CHAN_W-1:0] chan_sel_q,
    // pins and analog front end
    input  wire              ext_start_pin,
    input  wire              comp_high,
    output reg               input_route_switch_q,
    output reg               sample_conn_q,
    output reg  [2:0]        stage_autozero_ctl_q,
    output reg               midref_switch_q,
    output reg  [9:0]        ladder_tap_q
);

    localparam ST_IDLE   = 3'b001;
    localparam ST_SAMPLE = 3'b010;
    localparam ST_CONV   = 3'b100;

    reg  [3:0]  slot_q;
    reg  [5:0]  mc_q;
    reg  [2:0]  state_q;
    reg  [9:0]  sar_q;
    reg  [9:0]  trial_q;
    reg  [1:0]  flag_dly_q;
    reg         flag_pend_q;
    reg         pin_s1_q;
    reg         pin_s2_q;
    reg         pin_prev_q;
    reg         hw_req_q;
    reg         sw_req_q;
    reg         cmp_s1_q;
    reg         cmp_s2_q;
    wire        at_state6_phase2 = (slot_q == `SARSEQ_SLOT_STATE6_PHASE2);
    wire        at_state1_phase2 = (slot_q == `SARSEQ_SLOT_STATE1_PHASE2);
    wire        mc_end  = (slot_q == `SARSEQ_SLOT_LAST);
    wire        busy    = (state_q != ST_IDLE);
    wire        go_sw   = at_state6_phase2 && (sw_start_wr || sw_req_q) && !busy;
    wire        go_hw   = at_state1_phase2 && hw_req_q && !busy;
    wire        go      = go_sw || go_hw;

    // machine cycle slot counter
    always @(posedge clk) begin
        if (!nrst)
            slot_q <= 4'h0;
        else if (mc_end)
            slot_q <= 4'h0;
        else
            slot_q <= slot_q + 4'h1;
    end

    // pin and comparator synchronisers; only stage two is read
    always @(posedge clk) begin
        if (!nrst) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            cmp_s1_q <= 1'b0;
            cmp_s2_q <= 1'b0;
        end else begin
            pin_s1_q <= ext_start_pin;
            pin_s2_q <= pin_s1_q;
            cmp_s1_q <= comp_high;
            cmp_s2_q <= cmp_s1_q;
        end
    end

    // edge detect once a machine cycle; pin held one cycle each level
    always @(posedge clk) begin
        if (!nrst) begin
            pin_prev_q <= 1'b0;
            hw_req_q   <= 1'b0;
        end else begin
            if (at_state6_phase2) begin
                pin_prev_q <= pin_s2_q;
                if (pin_s2_q && !pin_prev_q)
                    hw_req_q <= 1'b1;
            end else if (go_hw || (busy && at_state1_phase2)) begin
                hw_req_q <= 1'b0;
            end
        end
    end

    // software write held until the next state6 phase2
    always @(posedge clk) begin
        if (!nrst)
            sw_req_q <= 1'b0;
        else if (at_state6_phase2)
            sw_req_q <= 1'b0;
        else if (sw_start_wr && !busy)
            sw_req_q <= 1'b1;
    end

    // channel field
    always @(posedge clk) begin
        if (!nrst)
            chan_sel_q <= {CHAN_W{1'b0}};
        else if (chan_sel_we && !busy)
            chan_sel_q <= chan_sel_wr;
    end

    // sequencer: start, sample interval, ten bit steps
    always @(posedge clk) begin
        if (!nrst) begin
            state_q       <= ST_IDLE;
            mc_q          <= 6'd0;
            start_pulse_q <= 1'b0;
        end else begin
            start_pulse_q <= go;
            case (state_q)
                ST_IDLE: begin
                    if (go) begin
                        state_q <= ST_SAMPLE;
                        mc_q    <= 6'd0;
                    end
                end
                ST_SAMPLE: begin
                    if (mc_end) begin
                        mc_q <= mc_q + 6'd1;
                        if (mc_q + 6'd1 == `SARSEQ_BIT_FIRST)
                            state_q <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (mc_end) begin
                        mc_q <= mc_q + 6'd1;
                        if (mc_q + 6'd1 == `SARSEQ_CONV_MC)
                            state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // bit steps: four machine cycles per decision, ten decisions fill cycles 8..47,
    // leaving two cycles to settle and transfer within the fixed 50
    wire [5:0] bit_mc   = mc_q - `SARSEQ_BIT_FIRST;
    wire       step_end = (state_q == ST_CONV) && mc_end && (bit_mc[1:0] == `SARSEQ_STEP_PHASE)
                          && (trial_q != `SARSEQ_ZERO10);
    always @(posedge clk) begin
        if (!nrst) begin
            sar_q   <= `SARSEQ_ZERO10;
            trial_q <= `SARSEQ_ZERO10;
        end else if (go) begin
            sar_q   <= `SARSEQ_MIDSCALE;
            trial_q <= `SARSEQ_MIDSCALE;
        end else if (step_end) begin
            // clear the trial bit when dac is above the input
            sar_q   <= (cmp_s2_q ? (sar_q & ~trial_q) : sar_q) | (trial_q >> 1);
            trial_q <= trial_q >> 1;
        end
    end

    // completion: transfer result, pulse done
    wire finish = (state_q == ST_CONV) && mc_end && (mc_q + 6'd1 == `SARSEQ_CONV_MC);
    always @(posedge clk) begin
        if (!nrst) begin
            result_q    <= `SARSEQ_ZERO10;
            conv_done_q <= 1'b0;
        end else begin
            conv_done_q <= finish;
            if (finish)
                result_q <= sar_q;
        end
    end

    // readable start flag lags internal start by two machine cycles
    always @(posedge clk) begin
        if (!nrst) begin
            flag_pend_q             <= 1'b0;
            flag_dly_q              <= 2'd0;
            conversion_start_flag_q <= 1'b0;
        end else begin
            if (go) begin
                flag_pend_q <= 1'b1;
                flag_dly_q  <= 2'd0;
            end else if (flag_pend_q && mc_end) begin
                if (flag_dly_q + 2'd1 == `SARSEQ_FLAG_DELAY) begin
                    flag_pend_q             <= 1'b0;
                    conversion_start_flag_q <= 1'b1;
                end
                flag_dly_q <= flag_dly_q + 2'd1;
            end
            if (finish)
                conversion_start_flag_q <= 1'b0;
        end
    end

    // analog switch controls
    always @(posedge clk) begin
        if (!nrst) begin
            input_route_switch_q <= 1'b0;
            sample_conn_q        <= 1'b0;
            stage_autozero_ctl_q <= 3'b000;
            midref_switch_q      <= 1'b0;
            ladder_tap_q         <= `SARSEQ_MIDSCALE;
        end else begin
            // pin routed through the sample interval, dac after
            input_route_switch_q <= (state_q == ST_SAMPLE);
            midref_switch_q      <= busy;
            sample_conn_q        <= (state_q == ST_SAMPLE) && (mc_q >= `SARSEQ_SMP_FIRST)
                                    && (mc_q <= `SARSEQ_SMP_LAST);
            // stages released in turn so each zeroes behind a settled one
            stage_autozero_ctl_q[0] <= (state_q == ST_SAMPLE) && (mc_q < `SARSEQ_AZ1_END);
            stage_autozero_ctl_q[1] <= (state_q == ST_SAMPLE) && (mc_q < `SARSEQ_AZ2_END);
            stage_autozero_ctl_q[2] <= (state_q == ST_SAMPLE) && (mc_q < `SARSEQ_AZ3_END);
            ladder_tap_q         <= (state_q == ST_CONV) ? sar_q : `SARSEQ_MIDSCALE;
        end
    end

endmodule // sarseq_core

//--- test/sarseq_props.sv
/* sarseq_props: port assertions for sarseq_core.
 assumes: bound to every sarseq_core; 12-clock machine cycle. */
`timescale 1ns/1ps
module sarseq_props #(
    parameter CHAN_W = 3
) (
    // clock and reset
    input wire logic              clk,
    input wire logic              nrst,
    // cpu and pin side
    input wire logic              sw_start_wr,
    input wire logic              ext_start_pin,
    input wire logic              conversion_start_flag_q,
    input wire logic              conv_done_q,
    input wire logic              start_pulse_q,
    input wire logic [CHAN_W-1:0] chan_sel_q,
    // analog front end
    input wire logic              input_route_switch_q,
    input wire logic              sample_conn_q,
    input wire logic [2:0]        stage_autozero_ctl_q,
    input wire logic              midref_switch_q,
    input wire logic [9:0]        ladder_tap_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // flag stays low for the first eight clocks, then reads one 14 to 18 clocks later
    sequence s_flag_late;
        !conversion_start_flag_q [*8] ##[14:18] conversion_start_flag_q;
    endsequence
    // capacitor connects then lets go four machine cycles later
    sequence s_sample_win;
        ##[20:28] $rose(sample_conn_q) ##[44:52] $fell(sample_conn_q);
    endsequence
    a_sw_start: assert property (sw_start_wr && !midref_switch_q |-> ##[1:14] start_pulse_q)
        else $error("software start not seen");
    a_pin_start: assert property ($rose(ext_start_pin) && !midref_switch_q |-> ##[1:30] start_pulse_q)
        else $error("pin edge did not start");
    a_flag_late: assert property (start_pulse_q |=> s_flag_late)
        else $error("start flag timing wrong");
    a_conv_length: assert property (start_pulse_q |-> ##[596:604] conv_done_q)
        else $error("conversion length wrong");
    a_sample_window: assert property (start_pulse_q |-> s_sample_win)
        else $error("sample window wrong");
    a_route_midscale: assert property ($fell(input_route_switch_q) |->
        midref_switch_q && ladder_tap_q == 10'h200 && stage_autozero_ctl_q == 3'h0)
        else $error("dac not at midscale");
    a_az_order: assert property ($fell(stage_autozero_ctl_q[1]) |-> stage_autozero_ctl_q == 3'h4)
        else $error("autozero order wrong");
    a_flag_clear: assert property (conv_done_q |-> ##[0:1] !conversion_start_flag_q)
        else $error("flag not cleared");
    a_chan_busy: assert property (midref_switch_q && $past(midref_switch_q) |-> $stable(chan_sel_q))
        else $error("channel changed while busy");
endmodule // sarseq_props
bind sarseq_core sarseq_props #(.CHAN_W(CHAN_W)) chk_u (.clk(clk), .nrst(nrst), .sw_start_wr(sw_start_wr),
    .ext_start_pin(ext_start_pin), .conversion_start_flag_q(conversion_start_flag_q), .conv_done_q(conv_done_q),
    .start_pulse_q(start_pulse_q), .chan_sel_q(chan_sel_q), .input_route_switch_q(input_route_switch_q),
    .sample_conn_q(sample_conn_q), .stage_autozero_ctl_q(stage_autozero_ctl_q),
    .midref_switch_q(midref_switch_q), .ladder_tap_q(ladder_tap_q));

//--- test/sarseq_front_model.sv
/* sarseq_front_model: trigger source and comparator facing the sequencer.
 assumes: fire is a one-clock pulse; vin is set by the bench. */
`timescale 1ns/1ps
module sarseq_front_model (
    // clock
    input wire logic       clk,
    // bench control
    input wire logic       fire,
    input wire logic [9:0] vin,
    // sequencer side
    input wire logic [9:0] ladder_tap_q,
    output logic           ext_start_pin,
    output logic           comp_high
);
    logic [5:0] hold_q = 6'h00;
    // pin high two machine cycles, low at rest so the low time is long
    always @(posedge clk) begin
        if (fire)
            hold_q <= 6'h18;
        else if (hold_q != 6'h00)
            hold_q <= hold_q - 6'h01;
    end
    assign ext_start_pin = hold_q != 6'h00;
    // comparator settles a clock late, as a real one would
    always @(posedge clk) comp_high <= ladder_tap_q > vin;
endmodule // sarseq_front_model

//--- test/sarseq_core_tb_top.sv
/* sarseq_core_tb_top: self-checking bench for the sequencer.
 assumes: front model drives pin and comparator; checker bound in. */
`timescale 1ns/1ps
module sarseq_core_tb_top;
    logic       clk, nrst, sw_start_wr, chan_sel_we, fire, flag, done, spulse, route, samp, mid, pin, comp;
    logic [2:0] chan_sel_wr, chan_q, az;
    logic [9:0] vin, result, tap;
    int         errors, checked;
    logic [9:0] vals [8] = '{10'h000, 10'h3ff, 10'h200, 10'h1ff, 10'h155, 10'h2aa, 10'h001, 10'h3fe};
    always #50 clk = ~clk;
    sarseq_core dut_u (.clk(clk), .nrst(nrst), .sw_start_wr(sw_start_wr), .chan_sel_wr(chan_sel_wr),
        .chan_sel_we(chan_sel_we), .conversion_start_flag_q(flag), .result_q(result), .conv_done_q(done),
        .start_pulse_q(spulse), .chan_sel_q(chan_q), .ext_start_pin(pin), .comp_high(comp),
        .input_route_switch_q(route), .sample_conn_q(samp), .stage_autozero_ctl_q(az),
        .midref_switch_q(mid), .ladder_tap_q(tap));
    sarseq_front_model model_u (.clk(clk), .fire(fire), .vin(vin), .ladder_tap_q(tap),
        .ext_start_pin(pin), .comp_high(comp));
    task automatic complete_run;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [9:0] got, input logic [9:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick;
        @(posedge clk);
        #1;
    endtask
    // one conversion; mid-cycle sample points keep slot jitter harmless
    task automatic run_conv(input logic [2:0] ch, input logic [9:0] v, input logic by_pin);
        int n;
        chan_sel_wr = ch;
        chan_sel_we = 1'b1;
        vin = v;
        tick;
        chan_sel_we = 1'b0;
        fire = by_pin;
        sw_start_wr = !by_pin;
        tick;
        fire = 1'b0;
        sw_start_wr = 1'b0;
        for (n = 0; n < 40 && spulse !== 1'b1; n++) tick;
        check({9'h0, spulse}, 10'h001);
        // sw waits at most one machine cycle; pin adds two sync clocks and the state1_phase2 offset
        check({9'h0, by_pin ? (n >= 5 && n <= 16) : (n <= 11)}, 10'h001);
        if (n >= 40) complete_run;
        for (n = 0; n < 700 && done !== 1'b1; n++) begin
            tick;
            case (n)
                11: check({9'h0, flag}, 10'h000);
                12: begin chan_sel_wr = ~ch; chan_sel_we = 1'b1; end
                13: chan_sel_we = 1'b0;
                14: check({7'h0, chan_q}, {7'h0, ch});
                35: check({9'h0, flag}, 10'h001);
                41: check({6'h0, samp, az}, 10'h00f);
                53: check({6'h0, route, az}, 10'h00e);
                77: check({6'h0, route, az}, 10'h00c);
                99: check({6'h0, route, samp, az[0], mid}, 10'h001);
                default: ;
            endcase
        end
        check({9'h0, n >= 598 && n <= 601}, 10'h001);
        if (n >= 700) complete_run;
        check(result, v);
        tick;
        check({9'h0, flag}, 10'h000);
    endtask
    initial begin
        {clk, nrst, sw_start_wr, chan_sel_we, fire, chan_sel_wr, vin} = '0;
        errors = 0;
        checked = 0;
        repeat (8) @(posedge clk);
        #1;
        check({1'b0, flag, done, spulse, route, samp, mid, az}, 10'h000);
        check(result, 10'h000);
        check(tap, 10'h200);
        nrst = 1'b1;
        // back to back, every channel, both start sources
        for (int i = 0; i < 8; i++) run_conv(i[2:0], vals[i], i[0]);
        complete_run;
    end
endmodule // sarseq_core_tb_top
